/* shared/etp_defs.vh */
// Register map, field positions and reset values of the 8-bit timer/PWM block.
// Included by the timer top and its register store; holds definitions only.
`ifndef ETP_DEFS_VH
`define ETP_DEFS_VH

// ----------------------------------------------------------------
// Register word addresses (byte address = 4 * word index)
// ----------------------------------------------------------------
`define ETP_IDX_MODE       4'h0
`define ETP_IDX_COUNT      4'h1
`define ETP_IDX_RELOAD     4'h2
`define ETP_IDX_IRQ        4'h3
`define ETP_ADDR_W         4

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define ETP_BIT_PWM_EN     0
`define ETP_BIT_TOGGLE_EN  1
`define ETP_BIT_RELOAD_EN  2
`define ETP_BIT_CLK_SRC    3
`define ETP_RATE_LSB       4
`define ETP_RATE_MSB       6
`define ETP_BIT_COUNT_EN   7

// ----------------------------------------------------------------
// Interrupt register fields
// ----------------------------------------------------------------
`define ETP_BIT_IRQ_FLAG   0
`define ETP_BIT_IRQ_EN     1

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define ETP_MODE_RST       8'h00
`define ETP_COUNT_RST      8'h00
`define ETP_RELOAD_RST     8'h00
`define ETP_COUNT_MAX      8'hFF
`define ETP_IRQ_VECTOR     8'h08
`define ETP_MASK_256       8'hFF
`define ETP_MASK_64        8'h3F
`define ETP_MASK_32        8'h1F
`define ETP_MASK_16        8'h0F

`endif

/* src/etp_reg_store.v */
// Small register store for the timer: mode word and reload word.
// Assumes a single clock and a synchronous active-low reset from the top.
`timescale 1ns/1ps
`default_nettype none
`include "etp_defs.vh"

module etp_reg_store (
  input  wire       clk_sys,
  input  wire       rstn,
  input  wire       ce,
  input  wire       wr_mode,
  input  wire       wr_reload,
  input  wire       clr_enable,
  input  wire [7:0] wdata,
  output reg  [7:0] mode_q,
  output reg  [7:0] reload_q
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rstn) begin
      mode_q   <= `ETP_MODE_RST;
      reload_q <= `ETP_RELOAD_RST;
    end else if (ce) begin
      if (wr_mode)
        mode_q <= wdata;
      else if (clr_enable)
        mode_q[`ETP_BIT_COUNT_EN] <= 1'b0;
      if (wr_reload)
        reload_q <= wdata;
    end
  end

endmodule // etp_reg_store
`default_nettype wire

/* src/etp_timer.v */
// 8-bit timer/counter with prescaler, event count, buzzer toggle and PWM.
// Assumes an Avalon-MM master on clk_sys and an asynchronous event pin.
//
// Overview of operation
// - Clearing count enable stops counting, buzzer toggling and PWM output.
// - Software clears the irq flag by writing zero; clears enable to mask.
// - Prescale select is the three-bit field in mode bits 4 to 6.
// - Clock source clear uses prescaled clock; set counts pin events.
// - PWM boundary 0..255 for reload/toggle 00, 0..63 for 01.
// - PWM boundary 0..31 for reload/toggle 10, 0..15 for 11.
// - Counter is writable; reload value used in auto-reload and PWM.
// - Reload enable, toggle enable and PWM enable select the function.
// - Counter leaving 0xFF for another value sets the irq flag, always.
// - Flag set then enable set requests interrupt next cycle, vector 8.
// - Prescale 000 divides by 256, halving to 111 dividing by 2.
// - Auto-reload copies the reload value into the counter on overflow.
// - Buzzer toggles once per interval, giving half the timer frequency.
// - PWM goes low at counter equal reload, high at counter zero.
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "etp_defs.vh"

module etp_timer #(
  parameter PRESCALE_W = 8
) (
  input  wire                    clk_sys,
  input  wire                    rstn,
  input  wire                    ce,
  input  wire [`ETP_ADDR_W-1:0]  avs_address,
  input  wire                    avs_read,
  input  wire                    avs_write,
  input  wire [31:0]             avs_writedata,
  output reg  [31:0]             avs_readdata,
  output reg                     avs_waitrequest,
  input  wire                    event_pin,
  output reg                     timer_out,
  output reg                     timer_out_en,
  output reg                     irq_req,
  output reg  [7:0]              irq_vector
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [7:0] bound_mask;
    input pwm;
    input rld;
    input tog;
    begin
      if (!pwm)
        bound_mask = `ETP_MASK_256;
      else if (!rld && !tog)
        bound_mask = `ETP_MASK_256;
      else if (!rld && tog)
        bound_mask = `ETP_MASK_64;
      else if (rld && !tog)
        bound_mask = `ETP_MASK_32;
      else
        bound_mask = `ETP_MASK_16;
    end
  endfunction

  // ----------------------------------------------------------------
  // Register bus: one wait cycle, answer on the second edge
  // ----------------------------------------------------------------
  wire        req       = avs_read | avs_write;
  wire        acc       = req & ~avs_waitrequest;
  wire        wr_acc    = acc & avs_write;
  wire        wr_mode   = wr_acc && (avs_address == `ETP_IDX_MODE);
  wire        wr_count  = wr_acc && (avs_address == `ETP_IDX_COUNT);
  wire        wr_reload = wr_acc && (avs_address == `ETP_IDX_RELOAD);
  wire        wr_irq    = wr_acc && (avs_address == `ETP_IDX_IRQ);
  wire [7:0]  wdata     = avs_writedata[7:0];

  reg  [7:0]  count_reg;
  reg  [7:0]  count_next;
  reg         irq_flag_reg;
  reg         irq_en_reg;
  reg  [PRESCALE_W-1:0] pre_reg;
  reg         pin_s1_reg;
  reg         pin_s2_reg;
  reg         pin_d_reg;
  reg         pwm_lvl_reg;
  reg         tog_reg;
  wire [7:0]  mode_q;
  wire [7:0]  reload_q;

  etp_reg_store u_store (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .ce         (ce),
    .wr_mode    (wr_mode),
    .wr_reload  (wr_reload),
    .clr_enable (1'b0),
    .wdata      (wdata),
    .mode_q     (mode_q),
    .reload_q   (reload_q)
  );

  wire        pwm_en    = mode_q[`ETP_BIT_PWM_EN];
  wire        tog_en    = mode_q[`ETP_BIT_TOGGLE_EN];
  wire        rld_en    = mode_q[`ETP_BIT_RELOAD_EN];
  wire        src_ext   = mode_q[`ETP_BIT_CLK_SRC];
  wire [2:0]  rate      = mode_q[`ETP_RATE_MSB:`ETP_RATE_LSB];
  wire        run       = mode_q[`ETP_BIT_COUNT_EN];
  wire [7:0]  mask      = bound_mask(pwm_en, rld_en, tog_en);

  always @(posedge clk_sys) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (ce) begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (req && avs_waitrequest && avs_read) begin
        if (avs_address == `ETP_IDX_MODE)
          avs_readdata <= {24'h00_0000, mode_q};
        else if (avs_address == `ETP_IDX_COUNT)
          avs_readdata <= {24'h00_0000, count_reg};
        else if (avs_address == `ETP_IDX_IRQ)
          avs_readdata <= {30'h0000_0000, irq_en_reg, irq_flag_reg};
        else
          avs_readdata <= 32'h0000_0000;  // Reload is write-only; unmapped reads zero
      end
    end
  end

  // ----------------------------------------------------------------
  // Tick sources
  // ----------------------------------------------------------------
  // Pin passes two flops before the edge detector looks at it
  always @(posedge clk_sys) begin
    if (!rstn) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_d_reg  <= 1'b0;
      pre_reg    <= {PRESCALE_W{1'b0}};
    end else if (ce) begin
      pin_s1_reg <= event_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_s2_reg;
      if (run)
        pre_reg <= pre_reg + 1'b1;
      else
        pre_reg <= {PRESCALE_W{1'b0}};
    end
  end

  // Rate 000 needs all 8 bits wrapping (/256); 111 needs bit 0 (/2)
  // Shift of 8 for rate 000 needs four bits; a 3-bit sum would wrap to zero
  wire [3:0]  shamt     = 4'h8 - {1'b0, rate};
  wire [PRESCALE_W-1:0] pre_lo_mask = ~({PRESCALE_W{1'b1}} << shamt);
  wire        int_tick  = ((pre_reg & pre_lo_mask) == pre_lo_mask);
  wire        ext_tick  = pin_s2_reg & ~pin_d_reg;
  wire        tick      = run & (src_ext ? ext_tick : int_tick);
  wire [7:0]  bounded   = count_reg & mask;
  wire        at_top    = (bounded == mask);
  wire        overflow  = tick & at_top;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always @* begin
    count_next = count_reg;
    if (wr_count)
      count_next = wdata;
    else if (overflow) begin
      if (rld_en && !pwm_en)
        count_next = reload_q;
      else
        count_next = count_reg & ~mask;
    end else if (tick)
      count_next = count_reg + 8'h01;
  end

  // Leaving 0xFF is seen on every path, written or counted
  wire leave_ff  = (count_reg == `ETP_COUNT_MAX) && (count_next != `ETP_COUNT_MAX);
  wire set_flag  = leave_ff | overflow;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      count_reg    <= `ETP_COUNT_RST;
      irq_flag_reg <= 1'b0;
      irq_en_reg   <= 1'b0;
      irq_req      <= 1'b0;
      irq_vector   <= 8'h00;
    end else if (ce) begin
      count_reg <= count_next;
      if (set_flag)
        irq_flag_reg <= 1'b1;
      else if (wr_irq && !wdata[`ETP_BIT_IRQ_FLAG])
        irq_flag_reg <= 1'b0;
      if (wr_irq)
        irq_en_reg <= wdata[`ETP_BIT_IRQ_EN];
      irq_req    <= irq_flag_reg & irq_en_reg;
      irq_vector <= `ETP_IRQ_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // Output pin: PWM has priority over the buzzer toggle
  // ----------------------------------------------------------------
  wire [7:0] cnt_b = count_next & mask;
  wire [7:0] rld_b = reload_q & mask;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      pwm_lvl_reg  <= 1'b0;
      tog_reg      <= 1'b0;
      timer_out    <= 1'b0;
      timer_out_en <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        pwm_lvl_reg <= 1'b0;
      end else if (cnt_b == rld_b) begin
        pwm_lvl_reg <= 1'b0;
      end else if (cnt_b == 8'h00) begin
        pwm_lvl_reg <= 1'b1;
      end
      if (overflow && tog_en && !pwm_en)
        tog_reg <= ~tog_reg;
      // Stopped: buzzer and PWM both hold low, pin still owned by the block
      timer_out_en <= pwm_en | tog_en;
      if (!run)
        timer_out <= 1'b0;
      else if (pwm_en)
        timer_out <= pwm_lvl_reg;
      else if (tog_en)
        timer_out <= tog_reg;
      else
        timer_out <= 1'b0;
    end
  end

endmodule // etp_timer
`default_nettype wire

/* test/etp_sva.sv */
// Checker for the timer top: bus handshake, interrupt and output rules.
// Sees only the top-level ports; bound to every timer instance below.
`timescale 1ns/1ps
`default_nettype none
module etp_sva_chk #(parameter PRESCALE_W = 8) (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        timer_out,
  input wire logic        timer_out_en,
  input wire logic        irq_req,
  input wire logic [7:0]  irq_vector
);
  logic [7:0] mode_q;
  logic       en_q;
  wire        wr_ok = avs_write && !avs_waitrequest && ce;
  wire        pin_mode = mode_q[0] | mode_q[1];
  // Shadow bits follow the edge at which a write completes
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mode_q <= 8'h00;
      en_q <= 1'b0;
    end else if (wr_ok && avs_address == 4'h0) begin
      mode_q <= avs_writedata[7:0];
    end else if (wr_ok && avs_address == 4'h3) begin
      en_q <= avs_writedata[1];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_rd_done; avs_read && !avs_waitrequest; endsequence
  chk_wait_one: assert property (s_req |=> !avs_waitrequest)
    else $error("bus access not answered in one cycle");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low for more than one cycle");
  chk_wait_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without a request");
  chk_mode_read: assert property (s_rd_done ##0 avs_address == 4'h0 |->
    avs_readdata[6:0] == mode_q[6:0])
    else $error("mode readback differs");
  chk_wo_zero: assert property (s_rd_done ##0 (avs_address == 4'h2 || avs_address > 4'h3) |->
    avs_readdata == 32'h0)
    else $error("write-only or unmapped read not zero");
  chk_irq_masked: assert property (!en_q |=> !irq_req)
    else $error("interrupt while masked");
  chk_irq_vector: assert property (irq_req |-> irq_vector == 8'h08)
    else $error("wrong interrupt vector");
  chk_stop_out: assert property (!mode_q[7] [*3] |-> !timer_out)
    else $error("output active while stopped");
  chk_out_en: assert property (1'b1 |=> timer_out_en == $past(pin_mode))
    else $error("pin enable does not follow mode");
endmodule // etp_sva_chk
bind etp_timer etp_sva_chk #(.PRESCALE_W(PRESCALE_W)) sva_u (.clk_sys(clk_sys), .rstn(rstn),
  .ce(ce), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .timer_out(timer_out), .timer_out_en(timer_out_en),
  .irq_req(irq_req), .irq_vector(irq_vector));
`default_nettype wire

/* test/etp_load_model.sv */
// Far-side model: event source on the count pin and a load watching the timer pin.
// The bench drives go and clr on clk_sys and reads the counts back.
`timescale 1ns/1ps
`default_nettype none
module etp_load_model (
  input  wire logic        clk_sys,
  input  wire logic        clr,
  input  wire logic        go,
  input  wire logic [7:0]  n_pulse,
  input  wire logic        timer_out,
  output logic             event_pin = 1'b0,
  output logic [15:0]      rise_cnt = 16'h0,
  output logic [15:0]      high_cnt = 16'h0
);
  logic [7:0] left_q = 8'h00;
  logic [2:0] ph_q = 3'h0;
  logic       last_q = 1'b0;
  // Pulses 4 clocks high and 4 low, wide enough for the pin synchroniser
  always @(posedge clk_sys) begin
    last_q <= timer_out;
    rise_cnt <= clr ? 16'h0 : rise_cnt + {15'h0, timer_out && !last_q};
    high_cnt <= clr ? 16'h0 : high_cnt + {15'h0, timer_out};
    ph_q <= go ? 3'h0 : ph_q + {2'h0, left_q != 8'h0};
    if (go)
      left_q <= n_pulse;
    else if (left_q != 8'h0 && ph_q == 3'h7)
      left_q <= left_q - 8'h01;
    event_pin <= left_q != 8'h0 && ph_q[2];
  end
endmodule // etp_load_model
`default_nettype wire

/* test/testbench.sv */
// Testbench for the timer: register tests over Avalon-MM plus event source and load.
// Assumes the design, its defs header, the checker and the load model are compiled.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, event_pin, timer_out, timer_out_en, irq_req;
  logic [7:0]  irq_vector, rd;
  logic [7:0]  n_pulse = 8'h00;
  logic        go = 1'b0;
  logic        clr = 1'b0;
  logic [15:0] rise_cnt, high_cnt;
  int          miscompares = 0;
  int          n_compared = 0;
  int          bnd [4] = '{256, 64, 32, 16};
  always #2.5 clk_sys = ~clk_sys;
  etp_timer dut_u (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .event_pin(event_pin),
    .timer_out(timer_out), .timer_out_en(timer_out_en), .irq_req(irq_req),
    .irq_vector(irq_vector));
  etp_load_model load_u (.clk_sys(clk_sys), .clr(clr), .go(go), .n_pulse(n_pulse),
    .timer_out(timer_out), .event_pin(event_pin), .rise_cnt(rise_cnt), .high_cnt(high_cnt));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk_rng(input logic [15:0] v, input int lo, input int hi);
    check({7'h0, (v >= lo) && (v <= hi)}, 8'h01);
  endtask
  // An extra edge after release keeps back-to-back calls from double-driving a strobe
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic bus_rd(input logic [3:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic pulse_clr;
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge clk_sys);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus_rd(i[3:0]);
      check(rd, 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      bus_wr(4'h0, {1'b0, i[2:0], 4'h0});
      bus_rd(4'h0);
      check(rd, {1'b0, i[2:0], 4'h0});
    end
    $display("done: reset values and prescale field");
    bus_wr(4'h1, 8'hFF);
    bus_wr(4'h3, 8'h00);
    bus_rd(4'h3);
    check(rd, 8'h00);
    bus_wr(4'h1, 8'h00);
    bus_rd(4'h3);
    check(rd, 8'h01);
    bus_wr(4'h3, 8'h03);
    @(posedge clk_sys);
    check({7'h0, irq_req}, 8'h01);
    check(irq_vector, 8'h08);
    bus_wr(4'h3, 8'h02);
    bus_rd(4'h3);
    check(rd, 8'h02);
    bus_wr(4'h3, 8'h00);
    $display("done: interrupt flag");
    // Pass 4 stands for rate 000, the slowest divider
    for (int i = 4; i < 8; i++) begin
      bus_wr(4'h1, 8'h00);
      bus_wr(4'h0, {1'b1, ((i == 4) ? 3'h0 : i[2:0]), 4'h0});
      repeat (40 << ((i == 4) ? 8 : 8 - i)) @(posedge clk_sys);
      bus_wr(4'h0, 8'h00);
      bus_rd(4'h1);
      chk_rng({8'h0, rd}, 39, 41);
    end
    $display("done: prescaler rates");
    bus_wr(4'h2, 8'hFC);
    bus_wr(4'h1, 8'hFC);
    bus_wr(4'h0, 8'h76);
    bus_wr(4'h0, 8'hF6);
    pulse_clr;
    repeat (159) @(posedge clk_sys);
    chk_rng(rise_cnt, 9, 11);
    check({7'h0, timer_out_en}, 8'h01);
    bus_rd(4'h1);
    check({rd[7:2], 2'b00}, 8'hFC);
    bus_wr(4'h0, 8'h00);
    repeat (3) @(posedge clk_sys);
    check({7'h0, timer_out}, 8'h00);
    $display("done: buzzer with reload");
    bus_wr(4'h1, 8'h00);
    bus_wr(4'h0, 8'hF8);
    n_pulse <= 8'h05;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (60) @(posedge clk_sys);
    bus_wr(4'h0, 8'h00);
    bus_rd(4'h1);
    check(rd, 8'h05);
    $display("done: event counting");
    for (int i = 0; i < 4; i++) begin
      bus_wr(4'h3, 8'h00);
      bus_wr(4'h2, 8'(bnd[i] / 4));
      bus_wr(4'h1, 8'h00);
      bus_wr(4'h0, {5'b11110, i[1:0], 1'b1});
      pulse_clr;
      repeat (bnd[i] * 4) @(posedge clk_sys);
      chk_rng(high_cnt, bnd[i] - 3, bnd[i] + 3);
      bus_rd(4'h3);
      check(rd, 8'h01);
    end
    bus_wr(4'h0, 8'h00);
    $display("done: pwm boundaries");
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
